// >>> pkg/ptd_pkg.sv
package ptd_pkg;
  // clock and processing step
  localparam int CLK_MHZ = 250;
  localparam int TICK_US = 5000;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  // release time default, counted in processing steps
  localparam int RELEASE_DEF_MS = 60;
  localparam logic [15:0] RELEASE_RST = 16'(RELEASE_DEF_MS * 1000 / TICK_US);

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TIME_DIAL = 8'h04;
  localparam logic [7:0] OFS_PICKUP_LEVEL = 8'h08;
  localparam logic [7:0] OFS_RELEASE_TIME = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_OP_COUNT = 8'h14;
  localparam logic [7:0] OFS_OP_DELAY = 8'h18;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h1C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;

  // control register fields
  localparam int CTRL_DELAYED_RELEASE = 0;
  localparam int CTRL_CLEAR_AFTER_RELEASE = 1;
  localparam int CTRL_CONTINUE_CALC = 2;
  localparam int CTRL_FORCE_ENABLE = 3;
  localparam int CTRL_CURVE = 4;
  localparam int CTRL_FORCE_KIND_LO = 8;
  localparam int CTRL_FORCE_PHASE_LO = 12;
  localparam logic [31:0] CTRL_RST = 32'h0000_0003;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_731F;

  // setting reset values: dial in hundredths, level in hundredths of nominal
  localparam logic [15:0] TIME_DIAL_RST = 16'h0064;
  localparam logic [15:0] PICKUP_LEVEL_RST = 16'h0078;

  // interrupt bits
  localparam int IRQ_START = 0;
  localparam int IRQ_TRIP = 1;
  localparam int IRQ_EXPIRE = 2;
  localparam int IRQ_W = 3;

  // inverse grading curve, coefficients in thousandths
  localparam logic [15:0] IG_A = 16'd339;
  localparam logic [15:0] IG_B = 16'd236;
  // steps per second (200) times 1000 over dial scale 100
  localparam logic [15:0] IG_SCALE = 16'd2000;
  // logarithmic curve in steps: 5.8 s, and 1.35*ln2*200 per log2 unit
  localparam logic [15:0] LOG_A_STEPS = 16'd1160;
  localparam logic [15:0] LOG_B_STEPS = 16'd187;
  // log2(100) in q8 via the same linear mantissa, so a dial of 1.00 cancels exactly
  localparam logic [15:0] LOG2_100_Q8 = 16'd1680;

  typedef enum logic {PTD_CURVE_IG, PTD_CURVE_LOG} ptd_curve_t;
  typedef enum logic [1:0] {PTD_FORCE_NORMAL, PTD_FORCE_START, PTD_FORCE_TRIP, PTD_FORCE_BLOCKED} ptd_force_t;
  typedef enum logic [1:0] {PTD_ST_IDLE, PTD_ST_ACTIVE, PTD_ST_RELEASE} ptd_state_t;
endpackage

// >>> verilog/ptd_delay_calc.sv
`timescale 1ns/100ps
module ptd_delay_calc #(
  parameter int DW = 24
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic curve_log,
  input wire logic [15:0] time_dial,
  input wire logic [15:0] pickup_level,
  input wire logic [15:0] meas_cur,
  output logic [DW-1:0] delay,
  output logic delay_valid
);
  localparam int NW = 48;

  // log2 in q8: leading one position plus linear mantissa
  function automatic logic [15:0] log2_q8(input logic [15:0] x);
    logic [3:0] p;
    logic [15:0] sh;
    p = 4'd0;
    for (int i = 0; i < 16; i++) begin
      if (x[i]) begin
        p = 4'(i);
      end
    end
    sh = x << (4'd15 - p);
    log2_q8 = {4'd0, p, sh[14:7]};
  endfunction

  // logarithmic curve evaluated as a sum of logs, no divider needed
  logic signed [19:0] log_arg;
  logic signed [31:0] log_steps;
  assign log_arg = 20'(log2_q8(meas_cur)) + 20'(ptd_pkg::LOG2_100_Q8)
                 - 20'(log2_q8(time_dial)) - 20'(log2_q8(pickup_level));
  // signed all through, so a current below dial times level lengthens the delay
  assign log_steps = $signed(32'(ptd_pkg::LOG_A_STEPS))
                   - (($signed(32'(ptd_pkg::LOG_B_STEPS)) * 32'(log_arg)) >>> 8);

  // inverse grading: steps = 2000*k*Im / (339*Im - 236*Iset)
  logic signed [33:0] ig_den;
  logic [NW-1:0] ig_num;
  assign ig_den = 34'(ptd_pkg::IG_A * 32'(meas_cur)) - 34'(ptd_pkg::IG_B * 32'(pickup_level));
  assign ig_num = NW'(ptd_pkg::IG_SCALE) * NW'(time_dial) * NW'(meas_cur);

  // restoring divider, restarted on any input change so the delay tracks the current
  logic [NW-1:0] quo;
  logic [NW-1:0] rem;
  logic [32:0] den;
  logic [5:0] bit_left;
  logic busy;
  logic [48:0] last_in;

  always_ff @(posedge clk) begin
    if (rst) begin
      busy <= 1'b0;
      quo <= '0;
      rem <= '0;
      den <= '0;
      bit_left <= '0;
      last_in <= '0;
    end else if (!busy || last_in != {curve_log, time_dial, pickup_level, meas_cur}) begin
      last_in <= {curve_log, time_dial, pickup_level, meas_cur};
      busy <= (ig_den > 0);
      quo <= ig_num;
      rem <= '0;
      den <= ig_den[32:0];
      bit_left <= 6'(NW);
    end else if (bit_left != 0) begin
      // shift one numerator bit in, subtract when it fits
      if ({rem[NW-2:0], quo[NW-1]} >= NW'(den)) begin
        rem <= {rem[NW-2:0], quo[NW-1]} - NW'(den);
        quo <= {quo[NW-2:0], 1'b1};
      end else begin
        rem <= {rem[NW-2:0], quo[NW-1]};
        quo <= {quo[NW-2:0], 1'b0};
      end
      bit_left <= bit_left - 6'd1;
    end else begin
      busy <= 1'b0;
    end
  end

  // result register; keeps the last good delay while a new division runs
  always_ff @(posedge clk) begin
    if (rst) begin
      delay <= '0;
      delay_valid <= 1'b0;
    end else if (curve_log) begin
      delay <= (log_steps < 0) ? '0 : (log_steps > 32'((1 << DW) - 1)) ? '1 : DW'(log_steps);
      delay_valid <= 1'b1;
    end else if (ig_den <= 0) begin
      // pick-up below curve asymptote: full-scale delay, trips only once the counter saturates
      delay <= '1;
      delay_valid <= 1'b1;
    end else if (busy && bit_left == 0) begin
      delay <= (quo > NW'((1 << DW) - 1)) ? '1 : DW'(quo);
      delay_valid <= 1'b1;
    end
  end
endmodule

// >>> verilog/ptd_timer.sv
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
module ptd_timer #(
  parameter int TICK_CYCLES = ptd_pkg::TICK_CYCLES,
  parameter int DW = 24
) (
  input wire logic clk,
  input wire logic rst,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // measurement side
  input wire logic [2:0] pickup_phase,
  input wire logic [15:0] measured_max_current,
  // stage outputs
  output logic stage_start,
  output logic stage_trip,
  output logic stage_blocked,
  output logic [2:0] start_phases,
  output logic [2:0] trip_phases,
  output logic irq
);
  logic [31:0] ctrl;
  logic [15:0] time_dial;
  logic [15:0] pickup_level;
  logic [15:0] release_time;
  localparam int IRQ_BITS = ptd_pkg::IRQ_W;
  logic [IRQ_BITS-1:0] irq_status;
  logic [IRQ_BITS-1:0] irq_mask;

  wire delayed_release = ctrl[ptd_pkg::CTRL_DELAYED_RELEASE];
  wire clear_after_release = ctrl[ptd_pkg::CTRL_CLEAR_AFTER_RELEASE];
  wire continue_calc = ctrl[ptd_pkg::CTRL_CONTINUE_CALC];
  wire force_enable = ctrl[ptd_pkg::CTRL_FORCE_ENABLE];
  wire [1:0] force_kind = ctrl[ptd_pkg::CTRL_FORCE_KIND_LO +: 2];
  wire [2:0] force_phases = ctrl[ptd_pkg::CTRL_FORCE_PHASE_LO +: 3];

  // processing step enable
  logic [31:0] tick_cnt;
  logic tick;
  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (tick_cnt == 32'(TICK_CYCLES - 1));
      tick_cnt <= (tick_cnt == 32'(TICK_CYCLES - 1)) ? '0 : tick_cnt + 32'd1;
    end
  end

  logic [DW-1:0] op_delay;
  logic delay_valid;
  ptd_delay_calc #(.DW(DW)) u_calc (
    .clk(clk),
    .rst(rst),
    .curve_log(ctrl[ptd_pkg::CTRL_CURVE]),
    .time_dial(time_dial),
    .pickup_level(pickup_level),
    .meas_cur(measured_max_current),
    .delay(op_delay),
    .delay_valid(delay_valid)
  );

  // pick-up / release sequencer
  ptd_pkg::ptd_state_t state;
  logic [15:0] rel_left;
  logic [DW-1:0] op_count;
  logic [2:0] phase_hold;
  logic expire;
  wire pick = |pickup_phase;
  wire at_delay = delay_valid && (op_count >= op_delay);

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ptd_pkg::PTD_ST_IDLE;
      rel_left <= '0;
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      unique case (state)
        ptd_pkg::PTD_ST_IDLE: begin
          if (pick) begin
            state <= ptd_pkg::PTD_ST_ACTIVE;
          end
        end
        ptd_pkg::PTD_ST_ACTIVE: begin
          if (!pick) begin
            state <= ptd_pkg::PTD_ST_RELEASE;
            rel_left <= release_time;
          end
        end
        ptd_pkg::PTD_ST_RELEASE: begin
          if (pick) begin
            state <= ptd_pkg::PTD_ST_ACTIVE;
          end else if (rel_left == 0) begin
            state <= ptd_pkg::PTD_ST_IDLE;
            expire <= 1'b1;
          end else if (tick) begin
            rel_left <= rel_left - 16'd1;
          end
        end
      endcase
    end
  end

  // operating time counter, saturating
  always_ff @(posedge clk) begin
    if (rst) begin
      op_count <= '0;
    end else if (state == ptd_pkg::PTD_ST_IDLE) begin
      op_count <= '0;
    end else if (state == ptd_pkg::PTD_ST_ACTIVE) begin
      if (!pick && !clear_after_release) begin
        op_count <= '0;
      end else if (tick && !at_delay && op_count != '1) begin
        op_count <= op_count + DW'(1);
      end
    end else if (continue_calc && tick && op_count != '1) begin
      op_count <= op_count + DW'(1);
    end
  end

  // stage outputs: real behaviour ored with forced status
  wire real_start = (state == ptd_pkg::PTD_ST_ACTIVE) || (state == ptd_pkg::PTD_ST_RELEASE && delayed_release);
  wire real_trip = (state == ptd_pkg::PTD_ST_ACTIVE) && pick && at_delay;
  wire f_start = force_enable && (force_kind == ptd_pkg::PTD_FORCE_START);
  wire f_trip = force_enable && (force_kind == ptd_pkg::PTD_FORCE_TRIP);
  always_ff @(posedge clk) begin
    if (rst) begin
      stage_start <= 1'b0;
      stage_trip <= 1'b0;
      stage_blocked <= 1'b0;
      start_phases <= '0;
      trip_phases <= '0;
      phase_hold <= '0;
    end else begin
      if (pick) begin
        phase_hold <= pickup_phase;
      end
      stage_start <= real_start || f_start || f_trip;
      stage_trip <= real_trip || f_trip;
      stage_blocked <= force_enable && (force_kind == ptd_pkg::PTD_FORCE_BLOCKED);
      start_phases <= (real_start ? phase_hold : 3'b000) | ((f_start || f_trip) ? force_phases : 3'b000);
      trip_phases <= (real_trip ? phase_hold : 3'b000) | (f_trip ? force_phases : 3'b000);
    end
  end

  // event edges for interrupts
  logic start_d;
  logic trip_d;
  always_ff @(posedge clk) begin
    if (rst) begin
      start_d <= 1'b0;
      trip_d <= 1'b0;
    end else begin
      start_d <= stage_start;
      trip_d <= stage_trip;
    end
  end
  wire [IRQ_BITS-1:0] irq_set = {expire, stage_trip & ~trip_d, stage_start & ~start_d};

  // axi write: address and data taken independently, answered when both held
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  wire do_write = aw_held && w_held && !s_axi_bvalid;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        old[8*i +: 8] = nw[8*i +: 8];
      end
    end
    merge = old;
  endfunction

  wire [31:0] ctrl_new = merge(ctrl, w_data, w_strb) & ptd_pkg::CTRL_WMASK;
  wire [31:0] dial_new = merge({16'h0000, time_dial}, w_data, w_strb);
  wire [31:0] lvl_new = merge({16'h0000, pickup_level}, w_data, w_strb);
  wire [31:0] rel_new = merge({16'h0000, release_time}, w_data, w_strb);
  wire [31:0] mask_new = merge(32'(irq_mask), w_data, w_strb);
  wire [31:0] clr_bits = merge(32'h0000_0000, w_data, w_strb);
  wire addr_ok_w = (aw_addr <= ptd_pkg::OFS_IRQ_MASK) && (aw_addr[1:0] == 2'b00);

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_ok_w ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // settings registers; read-only offsets accept and ignore writes
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= ptd_pkg::CTRL_RST;
      time_dial <= ptd_pkg::TIME_DIAL_RST;
      pickup_level <= ptd_pkg::PICKUP_LEVEL_RST;
      release_time <= ptd_pkg::RELEASE_RST;
      irq_mask <= '0;
    end else if (do_write) begin
      unique case (aw_addr)
        ptd_pkg::OFS_CTRL: ctrl <= ctrl_new;
        ptd_pkg::OFS_TIME_DIAL: time_dial <= dial_new[15:0];
        ptd_pkg::OFS_PICKUP_LEVEL: pickup_level <= lvl_new[15:0];
        ptd_pkg::OFS_RELEASE_TIME: release_time <= rel_new[15:0];
        ptd_pkg::OFS_IRQ_MASK: irq_mask <= mask_new[IRQ_BITS-1:0];
        default: ;
      endcase
    end
  end

  // sticky events, write one to clear; a new event beats the clear
  wire w1c = do_write && (aw_addr == ptd_pkg::OFS_IRQ_STATUS);
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_status <= '0;
      irq <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~(w1c ? clr_bits[IRQ_BITS-1:0] : '0)) | irq_set;
      irq <= |(irq_status & irq_mask);
    end
  end

  // axi read, one cycle after address is taken
  logic [31:0] rd_mux;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      ptd_pkg::OFS_CTRL: rd_mux = ctrl;
      ptd_pkg::OFS_TIME_DIAL: rd_mux = {16'h0000, time_dial};
      ptd_pkg::OFS_PICKUP_LEVEL: rd_mux = {16'h0000, pickup_level};
      ptd_pkg::OFS_RELEASE_TIME: rd_mux = {16'h0000, release_time};
      ptd_pkg::OFS_STATUS: rd_mux = {24'h00_0000, delay_valid, 1'b0, 2'(state), 1'b0, stage_blocked, stage_trip,
                                     stage_start};
      ptd_pkg::OFS_OP_COUNT: rd_mux = 32'(op_count);
      ptd_pkg::OFS_OP_DELAY: rd_mux = 32'(op_delay);
      ptd_pkg::OFS_IRQ_STATUS: rd_mux = 32'(irq_status);
      ptd_pkg::OFS_IRQ_MASK: rd_mux = 32'(irq_mask);
      default: begin
        rd_mux = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// >>> tb/ptd_timer_asserts.sv
`timescale 1ns/100ps
module ptd_timer_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [2:0] pickup_phase,
  input wire logic stage_start,
  input wire logic stage_trip,
  input wire logic stage_blocked
);
  logic forced;

  // forcing mirrored from control writes; assumes address and data are taken together
  always_ff @(posedge clk) begin
    if (rst) begin
      forced <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == ptd_pkg::OFS_CTRL) begin
      forced <= s_axi_wdata[ptd_pkg::CTRL_FORCE_ENABLE];
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // margin covers the write and ctrl registers behind the mirrored forcing, and the output register
  sequence pick_gone;
    (!forced && !(|pickup_phase)) [*5];
  endsequence

  a_write_answer: assert property (wr_take |-> ##2 s_axi_bvalid)
    else $error("write response not on time");
  a_read_answer: assert property (rd_take |=> s_axi_rvalid)
    else $error("read response not on time");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answer pending");
  a_start_follows: assert property ($rose(|pickup_phase) && !forced |-> ##2 stage_start)
    else $error("start not raised after pick-up");
  a_trip_needs_pick: assert property (pick_gone |-> !stage_trip)
    else $error("trip without pick-up");
  a_trip_with_start: assert property ($rose(stage_trip) |-> stage_start)
    else $error("trip without start");
  a_blocked_forced: assert property ($rose(stage_blocked) |-> forced)
    else $error("blocked without forcing");
endmodule

// >>> tb/ptd_pickup_model.sv
`timescale 1ns/100ps
module ptd_pickup_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] cur_a,
  input wire logic [15:0] cur_b,
  input wire logic [15:0] cur_c,
  input wire logic [15:0] level,
  output logic [2:0] pickup_phase,
  output logic [15:0] measured_max_current
);
  // registered comparator; level is the bench's own, so pick can drop while current stays
  always_ff @(posedge clk) begin
    if (rst) begin
      pickup_phase <= 3'h0;
      measured_max_current <= 16'h0000;
    end else begin
      pickup_phase <= {cur_c > level, cur_b > level, cur_a > level};
      measured_max_current <= (cur_a > cur_b) ? ((cur_a > cur_c) ? cur_a : cur_c) : ((cur_b > cur_c) ? cur_b : cur_c);
    end
  end
endmodule

// >>> tb/test_ptd_timer.sv
`timescale 1ns/100ps
module test_ptd_timer;
  logic clk, rst;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, c1;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [2:0] pickup_phase, start_phases, trip_phases;
  logic [15:0] measured_max_current, cur_a, cur_b, cur_c, lvl;
  logic stage_start, stage_trip, stage_blocked, irq;
  logic [9:0] snap;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int n;

  ptd_timer #(.TICK_CYCLES(10)) u_dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pickup_phase,
    .measured_max_current, .stage_start, .stage_trip, .stage_blocked, .start_phases, .trip_phases, .irq);
  ptd_pickup_model u_pick (.clk, .rst, .cur_a, .cur_b, .cur_c, .level(lvl), .pickup_phase, .measured_max_current);

  // clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // outputs sampled away from the launching edge
  always @(negedge clk) snap = {stage_start, stage_trip, stage_blocked, irq, start_phases, trip_phases};
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, ok;
    ta = 1'b0;
    tw = 1'b0;
    ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!ok) begin
      @(negedge clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      ok = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
  endtask
  task automatic rdr(input logic [7:0] a);
    logic ta, ok;
    ta = 1'b0;
    ok = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!ok) begin
      @(negedge clk);
      ta = s_axi_arvalid && s_axi_arready;
      ok = s_axi_rvalid;
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
  endtask
  // waits for start (sel 0) or trip (sel 1) to reach v, counting cycles in n
  task automatic wfor(input int sel, input logic v, input int mx);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (n < mx && (sel == 0 ? stage_start : stage_trip) !== v);
    @(posedge clk);
  endtask

  initial begin
    rst = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    {cur_a, cur_b, cur_c} = '0;
    lvl = 16'hFFFF;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdr(ptd_pkg::OFS_CTRL);
    check("ctrl reset", rd, 32'h0000_0003);
    rdr(ptd_pkg::OFS_RELEASE_TIME);
    check("release reset", rd, 32'h0000_000C);
    rdr(ptd_pkg::OFS_TIME_DIAL);
    check("dial reset", rd, 32'h0000_0064);
    rdr(8'h40);
    check("unmapped read", 32'(resp), 32'h0000_0002);
    wr(8'h44, 32'h0000_0000);
    check("unmapped write", 32'(resp), 32'h0000_0002);
    // inverse grading, dial 0.10, level 1.00, current 2.00: about 90 steps
    wr(ptd_pkg::OFS_PICKUP_LEVEL, 32'h0000_0064);
    wr(ptd_pkg::OFS_TIME_DIAL, 32'h0000_000A);
    cur_a <= 16'h00C8;
    lvl <= 16'h0064;
    wfor(1, 1'b1, 1200);
    check("trip time", n >= 870 && n <= 935, 1'b1);
    rdr(ptd_pkg::OFS_OP_DELAY);
    check("grading delay", rd >= 88 && rd <= 93, 1'b1);
    cur_a <= 16'h0190;
    repeat (100) @(posedge clk);
    rdr(ptd_pkg::OFS_OP_DELAY);
    check("delay follows current", rd >= 69 && rd <= 74, 1'b1);
    // default release: start held, counter held, then cleared
    lvl <= 16'hFFFF;
    repeat (30) @(posedge clk);
    rdr(ptd_pkg::OFS_OP_COUNT);
    c1 = rd;
    repeat (60) @(posedge clk);
    rdr(ptd_pkg::OFS_OP_COUNT);
    check("count held", rd, c1);
    check("start held", snap[9], 1'b1);
    repeat (40) @(posedge clk);
    check("start released", snap[9], 1'b0);
    rdr(ptd_pkg::OFS_OP_COUNT);
    check("count cleared", rd, 32'h0000_0000);
    // instant release with counter cleared at drop
    wr(ptd_pkg::OFS_CTRL, 32'h0000_0000);
    lvl <= 16'h0064;
    repeat (300) @(posedge clk);
    lvl <= 16'hFFFF;
    wfor(0, 1'b0, 8);
    check("instant release", n <= 5, 1'b1);
    rdr(ptd_pkg::OFS_OP_COUNT);
    check("count at drop", rd, 32'h0000_0000);
    // counting on during release passes the delay, yet no trip until pick returns
    wr(ptd_pkg::OFS_CTRL, 32'h0000_0007);
    cur_a <= 16'h00C8;
    // let the earlier release expire so the counter starts from zero
    repeat (150) @(posedge clk);
    lvl <= 16'h0064;
    repeat (850) @(posedge clk);
    lvl <= 16'hFFFF;
    repeat (20) @(posedge clk);
    rdr(ptd_pkg::OFS_OP_COUNT);
    c1 = rd;
    repeat (30) @(posedge clk);
    rdr(ptd_pkg::OFS_OP_COUNT);
    check("count advances", rd > c1, 1'b1);
    check("no trip in release", snap[8], 1'b0);
    lvl <= 16'h0064;
    wfor(1, 1'b1, 30);
    check("trip on return", snap[8], 1'b1);
    lvl <= 16'hFFFF;
    repeat (150) @(posedge clk);
    // logarithmic curve, dial 1.00, ratio 2: about 973 steps
    wr(ptd_pkg::OFS_CTRL, 32'h0000_0013);
    wr(ptd_pkg::OFS_TIME_DIAL, 32'h0000_0064);
    repeat (5) @(posedge clk);
    rdr(ptd_pkg::OFS_OP_DELAY);
    check("log delay", rd >= 960 && rd <= 985, 1'b1);
    wr(ptd_pkg::OFS_TIME_DIAL, 32'h0000_000A);
    cur_a <= 16'h03E8;
    repeat (5) @(posedge clk);
    rdr(ptd_pkg::OFS_OP_DELAY);
    check("negative delay", rd, 32'h0000_0000);
    lvl <= 16'h0064;
    wfor(1, 1'b1, 10);
    check("instant trip", n <= 6, 1'b1);
    lvl <= 16'hFFFF;
    cur_a <= 16'h0000;
    repeat (150) @(posedge clk);
    // every forced kind, phases A and C
    wr(ptd_pkg::OFS_IRQ_MASK, 32'h0000_0000);
    for (int k = 0; k < 4; k++) begin
      wr(ptd_pkg::OFS_CTRL, 32'h0000_5008 | (k << 8));
      repeat (4) @(posedge clk);
      check("forced start", snap[9], k == 1 || k == 2);
      check("forced trip", snap[8], k == 2);
      check("forced blocked", snap[7], k == 3);
      check("forced trip phases", snap[2:0], (k == 2) ? 3'h5 : 3'h0);
      check("masked irq", snap[6], 1'b0);
    end
    // real pick on phase B while forcing normal
    wr(ptd_pkg::OFS_CTRL, 32'h0000_0009);
    cur_b <= 16'h00C8;
    lvl <= 16'h0064;
    repeat (6) @(posedge clk);
    check("real start", snap[9], 1'b1);
    check("real phases", snap[5:3], 3'h2);
    rdr(ptd_pkg::OFS_STATUS);
    check("status word", rd, 32'h0000_0091);
    lvl <= 16'hFFFF;
    cur_b <= 16'h0000;
    wr(ptd_pkg::OFS_CTRL, 32'h0000_0003);
    repeat (150) @(posedge clk);
    // sticky trip event unmasked, then cleared
    wr(ptd_pkg::OFS_IRQ_MASK, 32'h0000_0002);
    repeat (3) @(posedge clk);
    check("irq raised", snap[6], 1'b1);
    wr(ptd_pkg::OFS_IRQ_STATUS, 32'h0000_0007);
    repeat (3) @(posedge clk);
    check("irq cleared", snap[6], 1'b0);
    rdr(ptd_pkg::OFS_IRQ_STATUS);
    check("irq status", rd, 32'h0000_0000);
    end_sim();
  end
endmodule

bind ptd_timer ptd_timer_asserts u_chk (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pickup_phase, .stage_start, .stage_trip, .stage_blocked);
